// ---- logic/iaa_pkg.sv ----
package iaa_pkg;
    // Source counts and numbering
    localparam int NUM_PIN    = 8;                   // External request pins
    localparam int NUM_PER    = 8;                   // On-chip peripheral requests
    localparam int NUM_PRIO   = NUM_PIN + NUM_PER;   // Sources with a priority field
    localparam int NUM_SRC    = NUM_PRIO + 1;        // Plus the non-maskable source
    localparam int NUM_DMA_CH = 4;                   // DMA channels that can steal a source
    localparam int SRC_W      = 5;                   // Width of a source identity
    localparam logic [4:0] SRC_NMI      = 5'h00;     // Identity of the non-maskable source
    localparam logic [4:0] SRC_PIN_BASE = 5'h01;     // First pin identity
    localparam logic [4:0] SRC_PER_BASE = 5'h09;     // First peripheral identity
    localparam logic [4:0] NMI_LEVEL    = 5'h10;     // Above any programmable level

    // Register byte offsets
    localparam logic [7:0] OFF_PRIO0 = 8'h00;        // Priority fields, four per word
    localparam logic [7:0] OFF_PRIO1 = 8'h04;
    localparam logic [7:0] OFF_PRIO2 = 8'h08;
    localparam logic [7:0] OFF_PRIO3 = 8'h0C;
    localparam logic [7:0] OFF_SENSE = 8'h10;        // Pin sense selects, edge select, level
    localparam logic [7:0] OFF_FLAG  = 8'h14;        // Pin pending flags
    localparam logic [7:0] OFF_DMAEN = 8'h18;        // DMA master and channel enables
    localparam logic [7:0] OFF_DMASL = 8'h1C;        // DMA channel source selects
    localparam logic [7:0] OFF_STAT  = 8'h20;        // Acceptance status, read only

    // Field positions
    localparam int SENSE_NMI_EDGE_BIT = 8;           // 0 falling, 1 rising
    localparam int SENSE_NMI_LVL_BIT  = 15;          // Live non-maskable pin level
    localparam int DMAEN_MASTER_BIT   = 0;           // Master enable
    localparam int DMAEN_CH_LSB       = 1;           // Channel enables start here
    localparam int DMASL_STRIDE       = 8;           // Byte per channel select
    localparam int STAT_REQ_BIT       = 31;          // Request held toward the CPU
    localparam int STAT_IND_BIT       = 30;          // Acceptance indicator level
    localparam int STAT_LVL_LSB       = 8;           // Accepted level [11:8]
    localparam int STAT_VEC_LSB       = 0;           // Accepted identity [4:0]

    // Reset values
    localparam logic [3:0] PRIO_RST  = 4'h0;
    localparam logic [7:0] SENSE_RST = 8'h00;
    localparam logic [1:0] AXI_OKAY  = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Acceptance sequencer
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,                            // Nothing forwarded
        ACC_REQ  = 2'b01,                            // Request held toward the CPU
        ACC_EXC  = 2'b10                             // CPU in exception entry
    } iaa_acc_t;
endpackage : iaa_pkg

// ---- logic/iaa_top.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - Highest programmed level wins selection
// - Losing edge requests stay pending
// - Both resets clear latched edge requests
// - Ties resolved by fixed source order
// - Forward only when level exceeds mask
// - Acceptance drives indicator pin low
// - Level/peripheral: indicator high once taken
// - Edge: indicator high at exception start
// - New acceptance in progress keeps indicator low
// - DMA judgment adds one state, peripherals
// - Compare takes two or three states
// - Latency at least ten or eleven
// - DMA routed sources leave arbitration, NMI excepted
// - DMA routed sources masked regardless level, NMI excepted
// - Software may withdraw pending edge pin requests
// - Edge flag cleared by write-zero or entry
// - Four-bit priority, fifteen is highest
// - Sense select: 0 low-level, 1 falling-edge
module iaa_top (
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic        MANUAL_RESET,
    input  wire logic        NMI_PIN,
    input  wire logic [7:0]  PIN_REQ_N,
    input  wire logic [7:0]  PERIPH_REQ,
    input  wire logic [3:0]  CPU_MASK_LEVEL,
    input  wire logic        CPU_EXC_START,
    input  wire logic        CPU_TAKEN,
    output logic             CPU_INT_REQ,
    output logic [3:0]       CPU_INT_LEVEL,
    output logic [4:0]       CPU_INT_VECTOR,
    output logic             ACCEPT_INDICATOR_OUT_N,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    localparam int NP = iaa_pkg::NUM_PIN;
    localparam int NQ = iaa_pkg::NUM_PER;
    localparam int NS = iaa_pkg::NUM_SRC;

    ////////////////////////////////////////////////////////////////////////////
    // State declarations
    logic [8:0]  s1_ff, s2_ff, s3_ff, stab_ff;       // Pin synchronisers, bit 8 is NMI
    logic [8:0]  nxt_s1, nxt_s2, nxt_s3, nxt_stab;
    logic [7:0]  edge_ff, nxt_edge;                  // Latched pin edge requests
    logic [7:0]  seen_ff, nxt_seen;                  // Flag read as one by software
    logic        nmi_ff, nxt_nmi;                    // Latched non-maskable request
    logic [7:0]  pstage_ff, nxt_pstage;              // Extra pin compare state
    logic [7:0]  qstage_ff, nxt_qstage;              // DMA judgment state for peripherals
    logic [3:0]  prio_ff [iaa_pkg::NUM_PRIO];        // Priority fields
    logic [3:0]  nxt_prio [iaa_pkg::NUM_PRIO];
    logic [8:0]  sense_ff, nxt_sense;                // Pin senses plus NMI edge select
    logic [4:0]  dmaen_ff, nxt_dmaen;                // Master and channel enables
    logic [4:0]  dmasl_ff [iaa_pkg::NUM_DMA_CH];     // Channel source selects
    logic [4:0]  nxt_dmasl [iaa_pkg::NUM_DMA_CH];
    logic        sel_v_ff, nxt_sel_v;                // Selected request valid
    logic [4:0]  sel_l_ff, nxt_sel_l;                // Selected level
    logic [4:0]  sel_i_ff, nxt_sel_i;                // Selected identity
    iaa_pkg::iaa_acc_t acc_ff, nxt_acc;              // Acceptance sequencer
    logic [3:0]  lvl_ff, nxt_lvl;                    // Level shown to the CPU
    logic [4:0]  vec_ff, nxt_vec;                    // Identity shown to the CPU
    logic        edgek_ff, nxt_edgek;                // Accepted request was edge sensed
    logic        ind_n_ff, nxt_ind_n;                // Indicator pin level
    logic        aw_ff, w_ff, bv_ff, rv_ff;          // Bus channel holds
    logic        nxt_aw, nxt_w, nxt_bv, nxt_rv;
    logic [7:0]  awa_ff, nxt_awa;                    // Held write address
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;       // Held write and read data
    logic [3:0]  ws_ff, nxt_ws;                      // Held write strobes
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;       // Responses

    logic [7:0]  pin_flag;                           // Visible pin flags
    logic [NS-1:0] dma_steal;                        // Sources routed to DMA
    logic        cmp_ok;                             // Selected level beats the mask
    logic        do_wr, do_rd, exc_clr;
    logic [31:0] rdat;                               // Read mux
    logic        rerr;

    ////////////////////////////////////////////////////////////////////////////
    // Pin flags and DMA routing
    always_comb begin
        for (int j = 0; j < NP; j++) begin
            // Low-level or latched falling edge
            pin_flag[j] = sense_ff[j] ? edge_ff[j] : ~stab_ff[j];
        end
        for (int s = 0; s < NS; s++) begin
            dma_steal[s] = 1'b0;
            for (int c = 0; c < iaa_pkg::NUM_DMA_CH; c++) begin
                // Master AND any enabled channel selecting s
                if (dmaen_ff[iaa_pkg::DMAEN_CH_LSB + c] && dmasl_ff[c] == 5'(s)) begin
                    dma_steal[s] = dmaen_ff[iaa_pkg::DMAEN_MASTER_BIT];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers, edge latches and request stages
    always_comb begin
        nxt_s1     = {NMI_PIN, PIN_REQ_N};
        nxt_s2     = s1_ff;
        nxt_s3     = s2_ff;
        nxt_stab   = stab_ff;
        nxt_edge   = edge_ff;
        nxt_seen   = seen_ff;
        nxt_nmi    = nmi_ff;
        exc_clr    = (acc_ff == iaa_pkg::ACC_REQ) && CPU_EXC_START;
        for (int j = 0; j <= NP; j++) begin
            // Change counts once stages two and three agree
            if (s2_ff[j] == s3_ff[j]) begin
                nxt_stab[j] = s3_ff[j];
            end
        end
        for (int j = 0; j < NP; j++) begin
            // Withdraw by write-zero after reading one
            if (do_wr && awa_ff == iaa_pkg::OFF_FLAG && ws_ff[0] && !wd_ff[j] && seen_ff[j]) begin
                nxt_edge[j] = 1'b0;
                nxt_seen[j] = 1'b0;
            end
            // Entry into exception processing clears its edge flag
            if (exc_clr && vec_ff == iaa_pkg::SRC_PIN_BASE + 5'(j)) begin
                nxt_edge[j] = 1'b0;
            end
            // Falling edge latched; it waits until exception entry
            if (stab_ff[j] && s2_ff[j] == s3_ff[j] && !s3_ff[j] && sense_ff[j]) begin
                nxt_edge[j] = 1'b1;
            end
            if (do_rd && S_AXI_ARADDR == iaa_pkg::OFF_FLAG && pin_flag[j]) begin
                nxt_seen[j] = 1'b1;
            end
        end
        if (exc_clr && vec_ff == iaa_pkg::SRC_NMI) begin
            nxt_nmi = 1'b0;
        end
        // NMI edge in the selected direction
        if (s2_ff[NP] == s3_ff[NP] && stab_ff[NP] != s3_ff[NP]
            && s3_ff[NP] == sense_ff[iaa_pkg::SENSE_NMI_EDGE_BIT]) begin
            nxt_nmi = 1'b1;
        end
        if (MANUAL_RESET) begin
            nxt_edge = '0;
            nxt_nmi  = 1'b0;
        end
        // Pins take one extra state before selection
        nxt_pstage = pin_flag & ~dma_steal[NS-NQ-1:1];
        // Peripherals take one DMA judgment state
        nxt_qstage = PERIPH_REQ & ~dma_steal[NS-1:NS-NQ];
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s1_ff <= '1; s2_ff <= '1; s3_ff <= '1; stab_ff <= '1;
            edge_ff <= '0;
            seen_ff <= '0; nmi_ff <= 1'b0;
            pstage_ff <= '0; qstage_ff <= '0;
        end else begin
            s1_ff <= nxt_s1; s2_ff <= nxt_s2; s3_ff <= nxt_s3; stab_ff <= nxt_stab;
            edge_ff <= nxt_edge; seen_ff <= nxt_seen; nmi_ff <= nxt_nmi;
            pstage_ff <= nxt_pstage; qstage_ff <= nxt_qstage;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Priority selection
    always_comb begin
        nxt_sel_v = nmi_ff;
        nxt_sel_l = nmi_ff ? iaa_pkg::NMI_LEVEL : 5'h00;
        nxt_sel_i = iaa_pkg::SRC_NMI;
        for (int k = 0; k < iaa_pkg::NUM_PRIO; k++) begin
            // Strictly greater keeps the earlier source on a tie
            if ((k < NP ? pstage_ff[k] : qstage_ff[k-NP])
                && (!nxt_sel_v || {1'b0, prio_ff[k]} > nxt_sel_l)) begin
                nxt_sel_v = 1'b1;
                nxt_sel_l = {1'b0, prio_ff[k]};
                nxt_sel_i = iaa_pkg::SRC_PIN_BASE + 5'(k);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acceptance sequencer
    always_comb begin
        // Only above the mask goes on
        cmp_ok    = sel_v_ff && sel_l_ff > {1'b0, CPU_MASK_LEVEL};
        nxt_acc   = acc_ff;
        nxt_lvl   = lvl_ff;
        nxt_vec   = vec_ff;
        nxt_edgek = edgek_ff;
        nxt_ind_n = ind_n_ff;
        case (acc_ff)
            iaa_pkg::ACC_IDLE: begin
                if (cmp_ok) begin
                    nxt_acc   = iaa_pkg::ACC_REQ;
                    nxt_ind_n = 1'b0;
                end
            end
            iaa_pkg::ACC_REQ: begin
                // Level and identity frozen until entry
                if (CPU_EXC_START) begin
                    nxt_acc = iaa_pkg::ACC_EXC;
                    if (edgek_ff) begin
                        nxt_ind_n = 1'b1;
                    end
                end
            end
            iaa_pkg::ACC_EXC: begin
                if (CPU_TAKEN) begin
                    if (cmp_ok) begin
                        nxt_acc   = iaa_pkg::ACC_REQ;
                        nxt_ind_n = 1'b0;
                    end else begin
                        nxt_acc   = iaa_pkg::ACC_IDLE;
                        nxt_ind_n = 1'b1;
                    end
                end
            end
            default: begin
                nxt_acc   = iaa_pkg::ACC_IDLE;
                nxt_ind_n = 1'b1;
            end
        endcase
        if (cmp_ok && acc_ff != iaa_pkg::ACC_REQ) begin
            nxt_lvl   = sel_l_ff[4] ? 4'hF : sel_l_ff[3:0];
            nxt_vec   = sel_i_ff;
            nxt_edgek = (sel_i_ff == iaa_pkg::SRC_NMI)
                        || (sel_i_ff < iaa_pkg::SRC_PER_BASE
                            && sense_ff[3'(sel_i_ff - iaa_pkg::SRC_PIN_BASE)]);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sel_v_ff <= 1'b0; sel_l_ff <= '0; sel_i_ff <= '0;
            acc_ff <= iaa_pkg::ACC_IDLE; lvl_ff <= '0; vec_ff <= '0;
            edgek_ff <= 1'b0; ind_n_ff <= 1'b1;
        end else begin
            sel_v_ff <= nxt_sel_v; sel_l_ff <= nxt_sel_l; sel_i_ff <= nxt_sel_i;
            acc_ff <= nxt_acc; lvl_ff <= nxt_lvl; vec_ff <= nxt_vec;
            edgek_ff <= nxt_edgek; ind_n_ff <= nxt_ind_n;
        end
    end

    assign CPU_INT_REQ            = (acc_ff == iaa_pkg::ACC_REQ);
    assign CPU_INT_LEVEL          = lvl_ff;
    assign CPU_INT_VECTOR         = vec_ff;
    assign ACCEPT_INDICATOR_OUT_N = ind_n_ff;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    always_comb begin
        do_wr = aw_ff && w_ff && !bv_ff;
        do_rd = S_AXI_ARVALID && !rv_ff;
        rdat  = '0;
        rerr  = 1'b0;
        case (S_AXI_ARADDR)
            iaa_pkg::OFF_PRIO0, iaa_pkg::OFF_PRIO1, iaa_pkg::OFF_PRIO2, iaa_pkg::OFF_PRIO3: begin
                for (int f = 0; f < 4; f++) begin
                    rdat[12-4*f +: 4] = prio_ff[4*int'(S_AXI_ARADDR[3:2]) + f];
                end
            end
            iaa_pkg::OFF_SENSE: rdat = {16'h0000, stab_ff[NP], 6'h00, sense_ff};
            iaa_pkg::OFF_FLAG:  rdat = {24'h000000, pin_flag};
            iaa_pkg::OFF_DMAEN: rdat = {27'h0000000, dmaen_ff};
            iaa_pkg::OFF_DMASL: begin
                for (int c = 0; c < iaa_pkg::NUM_DMA_CH; c++) begin
                    rdat[iaa_pkg::DMASL_STRIDE*c +: 5] = dmasl_ff[c];
                end
            end
            iaa_pkg::OFF_STAT: begin
                rdat[iaa_pkg::STAT_REQ_BIT]            = CPU_INT_REQ;
                rdat[iaa_pkg::STAT_IND_BIT]            = ind_n_ff;
                rdat[iaa_pkg::STAT_LVL_LSB +: 4]       = lvl_ff;
                rdat[iaa_pkg::STAT_VEC_LSB +: 5]       = vec_ff;
            end
            default: rerr = 1'b1;                    // Unmapped address
        endcase
        nxt_aw  = aw_ff || (S_AXI_AWVALID && S_AXI_AWREADY);
        nxt_w   = w_ff || (S_AXI_WVALID && S_AXI_WREADY);
        nxt_awa = (S_AXI_AWVALID && S_AXI_AWREADY) ? S_AXI_AWADDR : awa_ff;
        nxt_wd  = (S_AXI_WVALID && S_AXI_WREADY) ? S_AXI_WDATA : wd_ff;
        nxt_ws  = (S_AXI_WVALID && S_AXI_WREADY) ? S_AXI_WSTRB : ws_ff;
        nxt_bv  = bv_ff && !S_AXI_BREADY;
        nxt_br  = br_ff;
        nxt_rv  = rv_ff && !S_AXI_RREADY;
        nxt_rd  = rd_ff;
        nxt_rr  = rr_ff;
        nxt_prio  = prio_ff;
        nxt_sense = sense_ff;
        nxt_dmaen = dmaen_ff;
        nxt_dmasl = dmasl_ff;
        if (do_wr) begin
            nxt_aw = 1'b0;
            nxt_w  = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = iaa_pkg::AXI_OKAY;
            case (awa_ff)
                iaa_pkg::OFF_PRIO0, iaa_pkg::OFF_PRIO1,
                iaa_pkg::OFF_PRIO2, iaa_pkg::OFF_PRIO3: begin
                    for (int f = 0; f < 4; f++) begin
                        if (ws_ff[1 - f/2]) begin
                            nxt_prio[4*int'(awa_ff[3:2]) + f] = wd_ff[12-4*f +: 4];
                        end
                    end
                end
                iaa_pkg::OFF_SENSE: begin
                    if (ws_ff[0]) nxt_sense[7:0] = wd_ff[7:0];
                    if (ws_ff[1]) nxt_sense[8] = wd_ff[iaa_pkg::SENSE_NMI_EDGE_BIT];
                end
                iaa_pkg::OFF_FLAG: ;                 // Clears handled with the flags
                iaa_pkg::OFF_DMAEN: begin
                    if (ws_ff[0]) nxt_dmaen = wd_ff[4:0];
                end
                iaa_pkg::OFF_DMASL: begin
                    for (int c = 0; c < iaa_pkg::NUM_DMA_CH; c++) begin
                        if (ws_ff[c]) nxt_dmasl[c] = wd_ff[iaa_pkg::DMASL_STRIDE*c +: 5];
                    end
                end
                iaa_pkg::OFF_STAT: ;                 // Read only, write ignored
                default: nxt_br = iaa_pkg::AXI_SLVERR;
            endcase
        end
        if (do_rd) begin
            nxt_rv = 1'b1;
            nxt_rd = rdat;
            nxt_rr = rerr ? iaa_pkg::AXI_SLVERR : iaa_pkg::AXI_OKAY;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            aw_ff <= 1'b0; w_ff <= 1'b0; bv_ff <= 1'b0; rv_ff <= 1'b0;
            awa_ff <= '0; wd_ff <= '0; ws_ff <= '0; rd_ff <= '0;
            br_ff <= iaa_pkg::AXI_OKAY; rr_ff <= iaa_pkg::AXI_OKAY;
            for (int k = 0; k < iaa_pkg::NUM_PRIO; k++) prio_ff[k] <= iaa_pkg::PRIO_RST;
            sense_ff <= {1'b0, iaa_pkg::SENSE_RST};
            dmaen_ff <= '0;
            for (int c = 0; c < iaa_pkg::NUM_DMA_CH; c++) dmasl_ff[c] <= '0;
        end else begin
            aw_ff <= nxt_aw; w_ff <= nxt_w; bv_ff <= nxt_bv; rv_ff <= nxt_rv;
            awa_ff <= nxt_awa; wd_ff <= nxt_wd; ws_ff <= nxt_ws; rd_ff <= nxt_rd;
            br_ff <= nxt_br; rr_ff <= nxt_rr;
            prio_ff <= nxt_prio; sense_ff <= nxt_sense;
            dmaen_ff <= nxt_dmaen; dmasl_ff <= nxt_dmasl;
        end
    end

    assign S_AXI_AWREADY = !aw_ff && !bv_ff;
    assign S_AXI_WREADY  = !w_ff && !bv_ff;
    assign S_AXI_BVALID  = bv_ff;
    assign S_AXI_BRESP   = br_ff;
    assign S_AXI_ARREADY = !rv_ff;
    assign S_AXI_RVALID  = rv_ff;
    assign S_AXI_RDATA   = rd_ff;
    assign S_AXI_RRESP   = rr_ff;
endmodule : iaa_top

// ---- sim/iaa_cpu_model.sv ----
`timescale 1ns/1ps
// CPU side: waits, enters exception, reloads its mask
module iaa_cpu_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       en,
    input  wire logic [3:0] base_mask,
    input  wire logic [7:0] wait_cyc,
    input  wire logic       req,
    input  wire logic [3:0] lvl,
    output logic            exc,
    output logic            tkn,
    output logic [3:0]      mask
);
    logic [7:0] cnt_ff;     // Cycles waited
    logic       busy_ff;    // Entry under way
    logic [3:0] lvl_ff;     // Level held at entry
    // Idle, wait, entry, mask reload
    always_ff @(posedge clk) begin
        exc    <= 1'b0;
        tkn    <= 1'b0;
        cnt_ff <= cnt_ff + 8'h01;
        if (rst || !en) begin
            busy_ff <= 1'b0;
            cnt_ff  <= 8'h00;
            mask    <= base_mask;
        end else if (!busy_ff && !req) begin
            cnt_ff <= 8'h00;
        end else if (!busy_ff && cnt_ff == wait_cyc) begin
            exc     <= 1'b1;
            busy_ff <= 1'b1;
            cnt_ff  <= 8'h00;
            lvl_ff  <= lvl;
        end else if (busy_ff && cnt_ff == 8'h03) begin
            tkn     <= 1'b1;
            busy_ff <= 1'b0;
            cnt_ff  <= 8'h00;
            mask    <= lvl_ff;
        end
    end
endmodule : iaa_cpu_model

// ---- sim/iaa_monitor.sv ----
`timescale 1ns/1ps
module iaa_monitor (
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic [3:0] CPU_MASK_LEVEL,
    input wire logic       CPU_EXC_START,
    input wire logic       CPU_TAKEN,
    input wire logic       CPU_INT_REQ,
    input wire logic [3:0] CPU_INT_LEVEL,
    input wire logic [4:0] CPU_INT_VECTOR,
    input wire logic       ACCEPT_INDICATOR_OUT_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    // Entry start withdraws the request one edge later
    sequence s_entry;
        CPU_EXC_START ##1 !CPU_INT_REQ;
    endsequence
    a_ind_low_req: assert property (CPU_INT_REQ |-> !ACCEPT_INDICATOR_OUT_N)
        else $error("Indicator high during request");
    a_ind_fall_why: assert property ($fell(ACCEPT_INDICATOR_OUT_N) |-> CPU_INT_REQ)
        else $error("Indicator low without request");
    a_above_mask: assert property ($rose(CPU_INT_REQ) && CPU_INT_VECTOR != 5'h00
        |-> CPU_INT_LEVEL > $past(CPU_MASK_LEVEL)) else $error("Level not above mask");
    a_no_zero_lvl: assert property (CPU_INT_REQ |-> CPU_INT_LEVEL != 4'h0)
        else $error("Level zero forwarded");
    a_req_hold: assert property (CPU_INT_REQ && !CPU_EXC_START |=> CPU_INT_REQ
        && $stable(CPU_INT_LEVEL) && $stable(CPU_INT_VECTOR)) else $error("Request moved");
    a_entry_drop: assert property (CPU_EXC_START && !CPU_TAKEN |-> s_entry)
        else $error("Request kept after entry");
    a_req_fall_why: assert property ($fell(CPU_INT_REQ) |-> $past(CPU_EXC_START))
        else $error("Request dropped early");
    a_taken_free: assert property (CPU_TAKEN |=> ACCEPT_INDICATOR_OUT_N || CPU_INT_REQ)
        else $error("Indicator stuck low");
endmodule : iaa_monitor
bind iaa_top iaa_monitor mon (.CLK(CLK), .RESET(RESET), .CPU_MASK_LEVEL(CPU_MASK_LEVEL),
    .CPU_EXC_START(CPU_EXC_START), .CPU_TAKEN(CPU_TAKEN), .CPU_INT_REQ(CPU_INT_REQ),
    .CPU_INT_LEVEL(CPU_INT_LEVEL), .CPU_INT_VECTOR(CPU_INT_VECTOR),
    .ACCEPT_INDICATOR_OUT_N(ACCEPT_INDICATOR_OUT_N));

// ---- sim/iaa_top_bench.sv ----
`timescale 1ns/1ps
module iaa_top_bench;
    logic        CLK, RESET, mrst, nmi, aw, w, br, ar, rr, en;
    logic [7:0]  pin_n, per, awa, ara, wcyc;
    logic [7:0]  pin_q, per_q;
    logic        mrst_q, nmi_q;
    logic [3:0]  bmask;
    logic [31:0] wd, d;
    logic [1:0]  r;
    wire         req, ind, exc, tkn, awr, wr, bv, arr, rv;
    wire  [3:0]  mask, lvl;
    wire  [4:0]  vec;
    wire  [31:0] rdat;
    wire  [1:0]  bresp, rresp;
    int          bad_count, num_checks;
    // Pin and peripheral inputs launched at the clock edge
    always @(posedge CLK) {pin_q, per_q, mrst_q, nmi_q} <= {pin_n, per, mrst, nmi};
    iaa_top DUT (.CLK(CLK), .RESET(RESET), .MANUAL_RESET(mrst_q), .NMI_PIN(nmi_q),
        .PIN_REQ_N(pin_q), .PERIPH_REQ(per_q), .CPU_MASK_LEVEL(mask), .CPU_EXC_START(exc),
        .CPU_TAKEN(tkn), .CPU_INT_REQ(req), .CPU_INT_LEVEL(lvl), .CPU_INT_VECTOR(vec),
        .ACCEPT_INDICATOR_OUT_N(ind), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(aw),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(ar), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr));
    iaa_cpu_model cpu (.clk(CLK), .rst(RESET), .en(en), .base_mask(bmask), .wait_cyc(wcyc),
        .req(req), .lvl(lvl), .exc(exc), .tkn(tkn), .mask(mask));
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end
    initial begin
        #40000;
        bad_count++;
        print_verdict();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : step
    // One AXI4-Lite transfer; ready and answer sampled mid-cycle
    task automatic axi(input logic we, input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        @(posedge CLK);                             // One edge between transfers
        awa <= a;
        ara <= a;
        wd  <= v;
        aw  <= we;
        w   <= we;
        br  <= we;
        ar  <= !we;
        rr  <= !we;
        do begin
            @(negedge CLK);
            ta = we ? awr : arr;
            tw = wr;
            tb = we ? bv : rv;
            d  = rdat;
            r  = we ? bresp : rresp;
            @(posedge CLK);
            if (ta) aw <= 1'b0;
            if (ta) ar <= 1'b0;
            if (tw) w <= 1'b0;
        end while (!tb);
        br <= 1'b0;
        rr <= 1'b0;
    endtask : axi
    task automatic acc(input logic [4:0] v, input logic [3:0] l);
        int n;
        n = 0;
        while (req !== 1'b1 && n < 40) begin
            step(1);
            n++;
        end
        chk(32'(req), 32'h1);
        chk(32'(vec), 32'(v));
        chk(32'(lvl), 32'(l));
    endtask : acc
    // Let the CPU finish, then reload its mask
    task automatic remask(input logic [3:0] m);
        step(12);
        en    <= 1'b0;
        bmask <= m;
        step(1);
        en    <= 1'b1;
    endtask : remask
    task automatic pulse();
        pin_n <= 8'hFE;
        step(2);
        pin_n <= 8'hFF;
    endtask : pulse
    task automatic t_regs();
        chk(32'(ind), 32'h1);
        axi(1'b0, iaa_pkg::OFF_STAT, 32'h0);
        chk(d, 32'h40000000);
        axi(1'b0, 8'h24, 32'h0);
        chk(d, 32'h0);
        chk(32'(r), 32'(iaa_pkg::AXI_SLVERR));
    endtask : t_regs
    task automatic t_sel();
        axi(1'b1, iaa_pkg::OFF_PRIO2, 32'h00003955);
        per <= 8'h03;
        step(2);
        chk(32'(req), 32'h0);
        step(1);
        acc(5'h0A, 4'h9);
        step(12);
        chk(32'(ind), 32'h1);
        per <= 8'h0D;
        remask(4'h0);
        acc(5'h0B, 4'h5);
        step(16);
        chk(32'(req), 32'h0);
        remask(4'h4);
        acc(5'h0B, 4'h5);
        per <= 8'h00;
    endtask : t_sel
    task automatic t_dma();
        axi(1'b1, iaa_pkg::OFF_DMASL, 32'h0000000B);
        axi(1'b1, iaa_pkg::OFF_DMAEN, 32'h00000003);
        remask(4'h0);
        per <= 8'h0C;
        acc(5'h0C, 4'h5);
        per <= 8'h00;
        axi(1'b1, iaa_pkg::OFF_DMAEN, 32'h00000002);
        remask(4'h0);
        per <= 8'h04;
        acc(5'h0B, 4'h5);
        per <= 8'h00;
    endtask : t_dma
    task automatic t_edge();
        axi(1'b1, iaa_pkg::OFF_PRIO0, 32'h00007000);
        axi(1'b1, iaa_pkg::OFF_SENSE, 32'h00000001);
        wcyc <= 8'h00;
        remask(4'h0);
        pulse();
        acc(5'h01, 4'h7);
        step(2);
        chk(32'(ind), 32'h1);
        step(8);
        axi(1'b0, iaa_pkg::OFF_FLAG, 32'h0);
        chk(d, 32'h0);
        wcyc <= 8'h04;
    endtask : t_edge
    task automatic t_clear();
        remask(4'hF);
        pulse();
        step(8);
        axi(1'b0, iaa_pkg::OFF_FLAG, 32'h0);
        chk(d, 32'h1);
        axi(1'b1, iaa_pkg::OFF_FLAG, 32'h0);
        axi(1'b0, iaa_pkg::OFF_FLAG, 32'h0);
        chk(d, 32'h0);
        pulse();
        step(8);
        mrst <= 1'b1;
        step(1);
        mrst <= 1'b0;
        axi(1'b0, iaa_pkg::OFF_FLAG, 32'h0);
        chk(d, 32'h0);
        nmi <= 1'b0;
        acc(5'h00, 4'hF);
    endtask : t_clear
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        {RESET, nmi, en, mrst, aw, w, br, ar, rr} = 9'h1C0;
        {pin_n, per, awa, ara, wcyc} = 40'hFF00000004;
        {wd, bmask, bad_count, num_checks} = '0;
        repeat (20) @(posedge CLK);
        RESET <= 1'b0;
        step(1);
        t_regs();
        t_sel();
        t_dma();
        t_edge();
        t_clear();
        print_verdict();
    end
endmodule : iaa_top_bench
